// File: hdl/spef_defines.vh
// constants for the serial error flag block
// assumes inclusion by every design file of the block
`ifndef SPEF_DEFINES_VH
`define SPEF_DEFINES_VH
`define SPEF_BYTE_W 8
`define SPEF_BIT_CNT_W 3
`define SPEF_LAST_BIT 3'h7
`define SPEF_ZERO_BYTE 8'h00
`define SPEF_BUF_DEPTH 2
`endif

// File: hdl/spef_rx_buf.v
// two-entry receive buffer with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "spef_defines.vh"
module spef_rx_buf #(
  parameter W = `SPEF_BYTE_W
) (
  input wire core_clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= {W{1'b0}};
      mem_r[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule // spef_rx_buf
`default_nettype wire

// File: hdl/spef_core.v
// serial peripheral error flags: mode fault, overrun, write collision
// assumes cpu access strobes are one-cycle pulses on core_clk;
// serial pins arrive asynchronously and are synchronised here
// Summary of operation
// RL1 - as master, a low slave-select input raises a mode fault
// RL2 - mode fault sets its flag; interrupt only with irq enable
// RL3 - mode fault clears peripheral enable, stopping all driven outputs
// RL4 - mode fault clears master select, falling back to slave
// RL5 - mode fault clears by status read while set, then control write
// RL6 - other party keeps slave-select high during the clearing sequence
// RL7 - enable and master restore accepted during or after clearing
// RL8 - while mode fault set, enable/master set attempts are ignored
// RL9 - no mode fault as slave; old flag may persist
// RL10 - byte completing with transfer-complete still set is an overrun
// RL11 - overrun sets its flag; interrupt only with irq enable
// RL12 - after overrun the first byte is kept, later bytes dropped
// RL13 - overrun flag clears on a status register read
// RL14 - data write during a transfer is dropped, transfer undisturbed
// RL15 - write collision detected as master and as slave
// RL16 - write collision sets its flag, never an interrupt
// RL17 - received bytes buffered and read synchronously with the cpu
// RL18 - write collision clears by status read while set, then data access
`timescale 1ns/1ps
`default_nettype none
`include "spef_defines.vh"
module spef_core #(
  parameter W = `SPEF_BYTE_W
) (
  input wire core_clk,
  input wire rst_b,
  input wire ctrl_wr,
  input wire ctrl_peripheral_enable_bit,
  input wire ctrl_master_select_bit,
  input wire ctrl_serial_irq_enable,
  input wire status_rd,
  input wire data_wr,
  input wire data_rd,
  input wire [W-1:0] data_wdata,
  input wire sclk_pin,
  input wire ss_b_pin,
  input wire miso_pin,
  input wire mosi_pin,
  output reg peripheral_enable_bit,
  output reg master_select_bit,
  output reg serial_irq_enable,
  output reg mode_fault_flag,
  output reg overrun_flag,
  output reg write_collision_flag,
  output reg transfer_complete_flag,
  output reg serial_irq,
  output reg [W-1:0] serial_data_reg,
  output reg tx_busy,
  output reg sclk_out,
  output reg sclk_oe,
  output reg mosi_out,
  output reg mosi_oe,
  output reg miso_out,
  output reg miso_oe
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [1:0] sclk_s_r;
  reg [1:0] ss_s_r;
  reg [1:0] miso_s_r;
  reg [1:0] mosi_s_r;
  reg sclk_d_r;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      sclk_s_r <= 2'h0;
      ss_s_r <= 2'h3;
      miso_s_r <= 2'h0;
      mosi_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk_pin};
      ss_s_r <= {ss_s_r[0], ss_b_pin};
      miso_s_r <= {miso_s_r[0], miso_pin};
      mosi_s_r <= {mosi_s_r[0], mosi_pin};
      sclk_d_r <= sclk_s_r[1];
    end
  end
  wire sclk_rise = sclk_s_r[1] && !sclk_d_r;
  wire sclk_fall = !sclk_s_r[1] && sclk_d_r;
  wire ss_low = !ss_s_r[1];

  // ****************************************************************
  // master bit clock divider
  // ****************************************************************
  // master sclk runs at core_clk / (2 * DIV); one-cycle enable pulses
  parameter DIV = 4;
  reg [7:0] div_r;
  wire tick = (div_r == DIV[7:0] - 8'h1);
  always @(posedge core_clk) begin
    if (!rst_b || !tx_busy) begin
      div_r <= 8'h0;
    end else if (tick) begin
      div_r <= 8'h0;
    end else begin
      div_r <= div_r + 8'h1;
    end
  end

  // ****************************************************************
  // clear sequences
  // ****************************************************************
  reg mode_fault_flag_armed_r;
  reg write_collision_flag_armed_r;
  reg status_rd_seen_r;
  wire data_access = data_wr || data_rd;
  wire mode_fault_flag_seq_done = mode_fault_flag_armed_r && ctrl_wr; // RL5
  wire write_collision_flag_seq_done = write_collision_flag_armed_r && data_access; // RL18
  wire tc_seq_done = status_rd_seen_r && data_access;

  // ****************************************************************
  // shifter
  // ****************************************************************
  reg [W-1:0] shift_r;
  reg [`SPEF_BIT_CNT_W-1:0] bit_r;
  reg samp_r;
  reg byte_done;
  wire master_act = peripheral_enable_bit && master_select_bit;
  wire slave_act = peripheral_enable_bit && !master_select_bit && ss_low;
  wire mode_fault_flag_evt = master_act && ss_low; // RL1 RL9
  wire collide = data_wr && tx_busy; // RL14 RL15
  wire buf_in_ready;
  wire buf_out_valid;
  wire [W-1:0] buf_out_data;
  // a flag in its clearing access counts as cleared for the new byte
  wire tc_pending = transfer_complete_flag && !tc_seq_done; // RL10
  wire buf_push = byte_done && !tc_pending; // RL12

  // one msb-first step: top bit leaves, new bit enters at the bottom
  function [W-1:0] shift_in;
    input [W-1:0] cur;
    input nb;
    begin
      shift_in = {cur[W-2:0], nb};
    end
  endfunction

  function is_last_bit;
    input [`SPEF_BIT_CNT_W-1:0] cnt;
    begin
      is_last_bit = (cnt == `SPEF_LAST_BIT);
    end
  endfunction

  always @(posedge core_clk) begin
    if (!rst_b) begin
      shift_r <= `SPEF_ZERO_BYTE;
      bit_r <= {`SPEF_BIT_CNT_W{1'b0}};
      tx_busy <= 1'b0;
      samp_r <= 1'b0;
      byte_done <= 1'b0;
      sclk_out <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (!peripheral_enable_bit || mode_fault_flag_evt) begin
        tx_busy <= 1'b0; // RL3
        sclk_out <= 1'b0;
        bit_r <= {`SPEF_BIT_CNT_W{1'b0}};
      end else if (data_wr && !tx_busy) begin
        shift_r <= data_wdata;
        tx_busy <= 1'b1;
        bit_r <= {`SPEF_BIT_CNT_W{1'b0}};
      end else if (tx_busy && master_select_bit && tick) begin
        // collided writes never reach shift_r, so the byte runs on
        sclk_out <= ~sclk_out; // RL14
        if (!sclk_out) begin
          samp_r <= miso_s_r[1];
        end else begin
          shift_r <= shift_in(shift_r, samp_r);
          bit_r <= bit_r + 1'b1;
          if (is_last_bit(bit_r)) begin
            tx_busy <= 1'b0;
            byte_done <= 1'b1;
          end
        end
      end else if (slave_act) begin
        if (sclk_rise) begin
          samp_r <= mosi_s_r[1];
          tx_busy <= 1'b1;
        end else if (sclk_fall) begin
          shift_r <= shift_in(shift_r, samp_r);
          bit_r <= bit_r + 1'b1;
          if (is_last_bit(bit_r)) begin
            tx_busy <= 1'b0;
            byte_done <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // receive path
  // ****************************************************************
  // rx buffer is read on core_clk only, so no read collision exists
  spef_rx_buf #(.W(W)) u_rx_buf (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(shift_r),
    .out_valid(buf_out_valid),
    .out_ready(data_rd),
    .out_data(buf_out_data)
  ); // RL17

  // ****************************************************************
  // control bits
  // ****************************************************************
  // a mode fault outranks a control write landing in the same cycle for enable and master select; irq enable is still written
  always @(posedge core_clk) begin
    if (!rst_b) begin
      peripheral_enable_bit <= 1'b0;
      master_select_bit <= 1'b0;
      serial_irq_enable <= 1'b0;
    end else if (mode_fault_flag_evt) begin
      peripheral_enable_bit <= 1'b0; // RL3
      master_select_bit <= 1'b0; // RL4
      if (ctrl_wr) begin
        serial_irq_enable <= ctrl_serial_irq_enable;
      end
    end else if (ctrl_wr) begin
      serial_irq_enable <= ctrl_serial_irq_enable;
      if (!mode_fault_flag || mode_fault_flag_seq_done) begin
        peripheral_enable_bit <= ctrl_peripheral_enable_bit; // RL7
        master_select_bit <= ctrl_master_select_bit; // RL7
      end else begin
        // set attempts dropped; clearing still allowed
        peripheral_enable_bit <= peripheral_enable_bit & ctrl_peripheral_enable_bit; // RL8
        master_select_bit <= master_select_bit & ctrl_master_select_bit; // RL8
      end
    end
  end

  // ****************************************************************
  // mode fault flag
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      mode_fault_flag <= 1'b0;
      mode_fault_flag_armed_r <= 1'b0;
    end else begin
      if (mode_fault_flag_evt) begin
        mode_fault_flag <= 1'b1; // RL2
      end else if (mode_fault_flag_seq_done) begin
        mode_fault_flag <= 1'b0; // RL5
      end
      // only a status read that saw the flag opens the clearing window
      if (status_rd) begin
        mode_fault_flag_armed_r <= mode_fault_flag;
      end else if (ctrl_wr) begin
        mode_fault_flag_armed_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // overrun and transfer complete
  // ****************************************************************
  // transfer complete clears by status read then data access
  always @(posedge core_clk) begin
    if (!rst_b) begin
      overrun_flag <= 1'b0;
      transfer_complete_flag <= 1'b0;
      status_rd_seen_r <= 1'b0;
    end else begin
      if (byte_done && tc_pending) begin
        overrun_flag <= 1'b1; // RL10 RL11
      end else if (status_rd) begin
        overrun_flag <= 1'b0; // RL13
      end
      if (byte_done) begin
        transfer_complete_flag <= 1'b1;
      end else if (tc_seq_done) begin
        transfer_complete_flag <= 1'b0;
      end
      // a byte ending in the clearing access needs a fresh status read
      if (tc_seq_done) begin
        status_rd_seen_r <= 1'b0;
      end else if (status_rd && transfer_complete_flag) begin
        status_rd_seen_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // write collision flag
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      write_collision_flag <= 1'b0;
      write_collision_flag_armed_r <= 1'b0;
    end else begin
      if (collide) begin
        write_collision_flag <= 1'b1; // RL16 RL15
      end else if (write_collision_flag_seq_done) begin
        write_collision_flag <= 1'b0; // RL18
      end
      if (status_rd) begin
        write_collision_flag_armed_r <= write_collision_flag;
      end else if (data_access) begin
        write_collision_flag_armed_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // data register and interrupt
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      serial_data_reg <= `SPEF_ZERO_BYTE;
      serial_irq <= 1'b0;
    end else begin
      if (buf_out_valid && (data_rd || !transfer_complete_flag)) begin
        serial_data_reg <= buf_out_data; // RL12
      end
      // collision flag intentionally absent from the interrupt
      serial_irq <= serial_irq_enable &&
        (mode_fault_flag || overrun_flag || transfer_complete_flag); // RL2 RL11 RL16
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      sclk_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
    end else begin
      sclk_oe <= master_act && !mode_fault_flag_evt; // RL3
      mosi_oe <= master_act && !mode_fault_flag_evt;
      miso_oe <= slave_act;
      mosi_out <= shift_r[W-1];
      miso_out <= shift_r[W-1];
    end
  end
  wire unused_ok = buf_in_ready;
endmodule // spef_core
`default_nettype wire

// File: bench/spef_props.sv
// checker for the serial error flag core
// assumes binding onto spef_core; one clock domain
`timescale 1ns/1ps
`default_nettype none
module spef_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ctrl_wr,
  input wire logic status_rd,
  input wire logic data_wr,
  input wire logic tx_busy,
  input wire logic peripheral_enable_bit,
  input wire logic master_select_bit,
  input wire logic serial_irq_enable,
  input wire logic mode_fault_flag,
  input wire logic overrun_flag,
  input wire logic write_collision_flag,
  input wire logic serial_irq,
  input wire logic sclk_oe,
  input wire logic mosi_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic armed_r;
  // clearing window opens on a status read that saw the flag
  always @(posedge core_clk) begin
    if (!rst_b || !mode_fault_flag) armed_r <= 1'b0;
    else if (status_rd) armed_r <= 1'b1;
  end
  sequence s_fault;
    $rose(mode_fault_flag);
  endsequence
  sequence s_lock;
    mode_fault_flag && ctrl_wr && !armed_r && !status_rd;
  endsequence
  a_fault_drops_en: assert property (s_fault |-> !peripheral_enable_bit)
    else $error("enable kept on mode fault");
  a_fault_to_slave: assert property (s_fault |-> !master_select_bit)
    else $error("master kept on mode fault");
  a_fault_quiet: assert property (s_fault |-> !sclk_oe && !mosi_oe)
    else $error("outputs kept on mode fault");
  a_fault_as_mst: assert property (s_fault |-> $past(master_select_bit))
    else $error("mode fault raised as slave");
  a_fault_sticky: assert property (mode_fault_flag && !ctrl_wr |=> mode_fault_flag)
    else $error("mode fault cleared early");
  a_lock_bits: assert property (s_lock |=> !peripheral_enable_bit && !master_select_bit)
    else $error("enable set while locked");
  a_irq_gated: assert property (serial_irq |-> $past(serial_irq_enable))
    else $error("irq without enable");
  a_irq_raised: assert property ((mode_fault_flag || overrun_flag) && serial_irq_enable
    ##1 serial_irq_enable |-> serial_irq)
    else $error("irq missing");
  a_ovr_clear: assert property (status_rd |=> !overrun_flag)
    else $error("overrun kept after read");
  a_write_collision_flag_set: assert property (data_wr && tx_busy |=> write_collision_flag)
    else $error("collision not flagged");
endmodule // spef_props
`default_nettype wire

// File: bench/spef_peer.sv
// far-side serial master: frames bytes msb first, 200 ns clock
// assumes mode with clock idle low, data set before rising edge
`timescale 1ns/1ps
`default_nettype none
module spef_peer (
  output var logic sclk,
  output var logic mosi,
  output var logic ss_b
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ss_b = 1'b1;
  end
  task send(input logic [7:0] b);
    integer i;
    ss_b = 1'b0;
    #100;
    for (i = 7; i >= 0; i--) begin
      mosi = b[i];
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    // released line no longer shows the last bit
    mosi = ~mosi;
    #100 ss_b = 1'b1;
  endtask
  // select pulled low by a rival; back high before any clearing
  task rival;
    ss_b = 1'b0;
    #300 ss_b = 1'b1;
  endtask
endmodule // spef_peer
`default_nettype wire

// File: bench/tb.sv
// testbench for the serial error flag core
// assumes 40 MHz core clock, peer master on the serial pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, rst_b, ctrl_wr, c_en, c_ms, c_ie;
  logic status_rd, data_wr, data_rd, miso_pin;
  logic [7:0] data_wdata, a, b;
  logic [7:0] rnd = 8'h48;
  wire sclk, mosi, ss_b;
  wire en, ms, ie, mf, ov, wc, tc, irq, busy;
  wire [7:0] rdat;
  wire so, so_oe, mo, mo_oe, mi, mi_oe;
  integer n_errors = 0, n_tests = 0, k;
  spef_peer i_peer (.sclk(sclk), .mosi(mosi), .ss_b(ss_b));
  spef_core i_dut (.core_clk(core_clk), .rst_b(rst_b), .ctrl_wr(ctrl_wr),
    .ctrl_peripheral_enable_bit(c_en), .ctrl_master_select_bit(c_ms),
    .ctrl_serial_irq_enable(c_ie), .status_rd(status_rd), .data_wr(data_wr),
    .data_rd(data_rd), .data_wdata(data_wdata), .sclk_pin(sclk), .ss_b_pin(ss_b),
    .miso_pin(miso_pin), .mosi_pin(mosi), .peripheral_enable_bit(en),
    .master_select_bit(ms), .serial_irq_enable(ie), .mode_fault_flag(mf),
    .overrun_flag(ov), .write_collision_flag(wc), .transfer_complete_flag(tc),
    .serial_irq(irq), .serial_data_reg(rdat), .tx_busy(busy), .sclk_out(so),
    .sclk_oe(so_oe), .mosi_out(mo), .mosi_oe(mo_oe), .miso_out(mi), .miso_oe(mi_oe));
  function automatic logic [7:0] lf(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task cw(input logic e, input logic m, input logic q);
    @(negedge core_clk);
    {ctrl_wr, c_en, c_ms, c_ie} = {1'b1, e, m, q};
    @(negedge core_clk);
    ctrl_wr = 1'b0;
  endtask
  task sr;
    @(negedge core_clk) status_rd = 1'b1;
    @(negedge core_clk) status_rd = 1'b0;
  endtask
  task dr;
    @(negedge core_clk) data_rd = 1'b1;
    @(negedge core_clk) data_rd = 1'b0;
  endtask
  task dw(input logic [7:0] d);
    @(negedge core_clk) {data_wr, data_wdata} = {1'b1, d};
    @(negedge core_clk) data_wr = 1'b0;
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // miso gets fresh noise every cycle
  always @(negedge core_clk) begin
    rnd <= lf(rnd);
    miso_pin <= rnd[0];
  end
  initial begin
    #400000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    {rst_b, ctrl_wr, c_en, c_ms, c_ie, status_rd, data_wr, data_rd} = 0;
    data_wdata = 8'h00;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    chk({en, ms, mf, ov, wc, tc, irq, busy}, 8'h00);
    // mode fault while master
    cw(1, 1, 1);
    i_peer.rival;
    repeat (6) @(negedge core_clk);
    chk({mf, en, ms, irq, so_oe, mo_oe}, 6'b100100);
    cw(1, 1, 1);
    chk({mf, en, ms}, 3'b100);
    sr;
    cw(1, 1, 1);
    chk({mf, en, ms, ie}, 4'b0111);
    // slave reception, overrun keeps first byte
    cw(1, 0, 1);
    a = rnd;
    b = ~rnd;
    i_peer.send(a);
    repeat (8) @(negedge core_clk);
    chk({tc, mf, ov}, 3'b100);
    i_peer.send(b);
    repeat (8) @(negedge core_clk);
    chk({ov, irq}, 2'b11);
    sr;
    chk(ov, 1'b0);
    dr;
    chk(rdat, a);
    // collision as master, then as slave
    for (k = 0; k < 2; k++) begin
      cw(1, k == 0, 1);
      a = rnd;
      if (k == 0) begin
        dw(a);
        @(negedge core_clk);
        chk({mo, mo_oe}, {a[7], 1'b1});
      end else begin
        fork i_peer.send(a); join_none
      end
      repeat (20) @(negedge core_clk);
      chk({busy, so_oe, mi_oe}, (k == 0) ? 3'b110 : 3'b101);
      dw(~a);
      chk({wc, irq}, 2'b10);
      for (int t = 0; t < 400 && busy; t++) @(negedge core_clk);
      chk({busy, so}, 2'b00);
      sr;
      dr;
      chk(wc, 1'b0);
      if (k == 1) begin
        chk(rdat, a);
        chk(mi, a[7]);
      end
      wait (ss_b);
      sr;
    end
    report_and_stop;
  end
endmodule // tb
bind spef_core spef_props i_props (.core_clk(core_clk), .rst_b(rst_b), .ctrl_wr(ctrl_wr),
  .status_rd(status_rd), .data_wr(data_wr), .tx_busy(tx_busy),
  .peripheral_enable_bit(peripheral_enable_bit), .master_select_bit(master_select_bit),
  .serial_irq_enable(serial_irq_enable), .mode_fault_flag(mode_fault_flag),
  .overrun_flag(overrun_flag), .write_collision_flag(write_collision_flag),
  .serial_irq(serial_irq), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe));
`default_nettype wire
